// ===== pkg/clf_defines.vh
// register map, field positions, reset values and timing constants of the logic blocks
`ifndef CLF_DEFINES_VH
`define CLF_DEFINES_VH

// register indices (byte address = index * 4)
`define CLF_IDX_VAR_VALUE  5'd0
`define CLF_IDX_VAR_DATA   5'd1
`define CLF_IDX_VAR_TRIG   5'd2
`define CLF_IDX_VAR_THR    5'd3
`define CLF_IDX_VAR_FUNC   5'd4
`define CLF_IDX_COND_IN1   5'd5
`define CLF_IDX_COND_OPS   5'd9
`define CLF_IDX_SR_SET     5'd10
`define CLF_IDX_SR_RST     5'd11
`define CLF_IDX_SR_THR     5'd12
`define CLF_IDX_DTC_CFG0   5'd13
`define CLF_IDX_TX_PGN0    5'd18
`define CLF_IDX_TX_RATE0   5'd24
`define CLF_IDX_STATUS     5'd30
`define CLF_NUM_CFG        30

// field positions
`define CLF_OP1_LSB        0
`define CLF_OP2_LSB        4
`define CLF_OP3_LSB        8
`define CLF_SET_MIN_LSB    0
`define CLF_SET_MAX_LSB    8
`define CLF_RST_MIN_LSB    16
`define CLF_RST_MAX_LSB    24
`define CLF_DTC_FMI_LSB    19
`define CLF_TX_PRIO_LSB    18
`define CLF_TX_DA_LSB      21
`define CLF_TX_SIGEN_LSB   16

// codes
`define CLF_FUNC_MINUS     4'd10
`define CLF_PF_PDU2_MIN    8'hf0
`define CLF_GLOBAL_ADDR    8'hff

// reset values
`define CLF_PRIO_RESET     3'd6
`define CLF_PGN_PROPB_BASE 18'h0ff00
`define CLF_SIGEN_RESET    4'hf

// timing: one tick per millisecond at 200 MHz
`define CLF_PCLK_MHZ       200
`define CLF_TICK_US        1000
`define CLF_TICK_CYCLES    (`CLF_TICK_US * `CLF_PCLK_MHZ)
`define CLF_SAVE_GAP_MS    14'd10000
`define CLF_DTC_HOLD_MS    12'd3000
`define CLF_HOLDOFF_MS     13'd5000

`endif

// ===== design/clf_top.v
// configurable logic blocks: variable, conditional, set/reset, dtc react, transmit scheduler
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Behaviour
// - true update compare loads and saves variable
// - one save per true, false rearms
// - saves spaced at least ten seconds
// - conditional output is only zero or one
// - comparators codes 0..6 on input pairs
// - codes 7..9 give or, and, xor
// - third operator combines both comparator results
// - reset dominant latch, starts off, holds
// - latch inputs use min/max percent thresholds
// - five spn/fmi pairs set state on match
// - state clears after three seconds without match
// - six transmit messages with four signals
// - periodic send, zero rate disables unless shared
// - shared pgn bundle timed by lowest message
// - no transmit during five second hold-off
// - default pgns are proprietary b broadcasts
// - default transmit priority is six
// - destination used only for pdu1 pgns
// - variable value readable and writable by software
// - unused signals are disabled and omitted
`include "clf_defines.vh"

module clf_top #(
  parameter TICK_CYCLES = `CLF_TICK_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        dm1_valid,
  input  wire [18:0] dm1_spn,
  input  wire [4:0]  dm1_fmi,
  output reg         nv_save,
  output reg  [31:0] nv_data,
  output reg         cond_out,
  output reg         sr_out,
  output reg  [4:0]  dtc_state,
  output reg         tx_req,
  output reg  [5:0]  tx_bundle,
  output reg  [17:0] tx_pgn,
  output reg  [2:0]  tx_prio,
  output reg  [7:0]  tx_da,
  output reg  [23:0] tx_sig_en
);

  // comparison and logic operators shared by variable and conditional blocks
  function cmp;
    input [3:0]  op;
    input [31:0] a;
    input [31:0] b;
    begin
      case (op)
        4'd1: cmp = (a == b);
        4'd2: cmp = (a != b);
        4'd3: cmp = (a > b);
        4'd4: cmp = (a >= b);
        4'd5: cmp = (a < b);
        4'd6: cmp = (a <= b);
        4'd7: cmp = (a != 0) | (b != 0);
        4'd8: cmp = (a != 0) & (b != 0);
        4'd9: cmp = (a != 0) ^ (b != 0);
        default: cmp = 1'b0;
      endcase
    end
  endfunction

  // threshold with dead band: on at max, off at min, else hold
  function thr_state;
    input [31:0] src;
    input [7:0]  tmin;
    input [7:0]  tmax;
    input        prev;
    begin
      if (src >= {24'h0, tmax})
        thr_state = 1'b1;
      else if (src <= {24'h0, tmin})
        thr_state = 1'b0;
      else
        thr_state = prev;
    end
  endfunction

  // loop indices, one per process, so no two processes share one
  integer i;
  integer rf_i;
  integer tx_i;
  genvar  g;

  reg  [31:0] cfg [0:`CLF_NUM_CFG-1];   // software register file
  reg  [17:0] tick_cnt;                 // millisecond prescaler
  reg         tick;                     // one-cycle millisecond pulse
  reg         save_armed;               // set by reset or a false evaluation
  reg  [13:0] gap_cnt;                  // ms left before next save allowed
  reg  [12:0] hold_cnt;                 // ms left of power-up hold-off
  reg         set_on;                   // thresholded set input
  reg         rst_on;                   // thresholded reset input
  reg  [5:0]  tx_pend;                  // leaders due to send
  wire [4:0]  idx;                      // word index of address
  wire        mapped;                   // address hits a register
  wire        acc;                      // access phase, answer cycle
  wire        wr_ok;                    // write takes effect now
  wire [31:0] status;                   // read-only block state
  wire        var_true;                 // variable update function
  wire        op1_res;                  // first_comparator_result
  wire        op2_res;                  // second_comparator_result
  wire        hold_done;                // transmit hold-off over
  wire        do_save;                  // save this cycle
  wire [5:0]  leader;                   // lowest message of its pgn
  wire [5:0]  fire;                     // leader period expired on tick
  wire [17:0] pgn  [0:5];               // pgn of each message
  wire [15:0] rate [0:5];               // interval in ms
  reg  [5:0]  members [0:5];            // messages bundled with leader
  reg  [5:0]  pick;                     // lowest pending leader one-hot
  reg  [2:0]  pick_n;                   // its index
  wire [4:0]  dtc_hit;                  // pair matched this cycle
  wire [4:0]  dtc_expire;               // pair silent for the hold time

  // bus decode: word index, mapped range, answer cycle
  assign idx    = paddr[6:2];
  assign mapped = (paddr[31:7] == 25'h0) && (paddr[1:0] == 2'b00) && (idx <= `CLF_IDX_STATUS);
  assign acc    = psel & penable & ~pready;
  assign wr_ok  = psel & penable & pready & pwrite & ~pslverr;
  assign hold_done = (hold_cnt == 13'd0);

  // variable update function: codes of the comparator table, or trigger minus threshold
  assign var_true = (cfg[`CLF_IDX_VAR_FUNC][3:0] == `CLF_FUNC_MINUS) ?
                    (cfg[`CLF_IDX_VAR_TRIG] > cfg[`CLF_IDX_VAR_THR]) :
                    cmp(cfg[`CLF_IDX_VAR_FUNC][3:0], cfg[`CLF_IDX_VAR_TRIG],
                        cfg[`CLF_IDX_VAR_THR]);
  // a save needs a true function, the armed flag (set by reset or a seen false) and an expired gap
  assign do_save = var_true & save_armed & (gap_cnt == 14'd0);

  // the two comparators on input pairs 1/2 and 3/4
  assign op1_res = cmp(cfg[`CLF_IDX_COND_OPS][`CLF_OP1_LSB +: 4],
                       cfg[`CLF_IDX_COND_IN1], cfg[`CLF_IDX_COND_IN1 + 5'd1]);
  assign op2_res = cmp(cfg[`CLF_IDX_COND_OPS][`CLF_OP2_LSB +: 4],
                       cfg[`CLF_IDX_COND_IN1 + 5'd2], cfg[`CLF_IDX_COND_IN1 + 5'd3]);

  // [8] armed, [7] hold-off over, [6:2] faults, [1] latch, [0] cond
  assign status = {23'h0, save_armed, hold_done, dtc_state, sr_out, cond_out};

  // per-message fields and bundle grouping
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_msg
      reg [15:0] per_cnt;   // ms since last send of this leader
      assign pgn[g]  = cfg[`CLF_IDX_TX_PGN0 + g][17:0];
      assign rate[g] = cfg[`CLF_IDX_TX_RATE0 + g][15:0];
      // a message leads its group when no lower one shares its pgn
      if (g == 0) begin : g_first
        assign leader[g] = 1'b1;
      end else begin : g_rest
        assign leader[g] = ~|(members_below(g, pgn[g]));
      end
      // zero rate on the leader stops the group
      assign fire[g] = tick & hold_done & leader[g] & (rate[g] != 16'h0) &
                       (per_cnt >= rate[g] - 16'd1);

      // period counter, runs only for enabled leaders after hold-off
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          per_cnt <= 16'h0;
        end else if (!leader[g] || rate[g] == 16'h0 || !hold_done) begin
          per_cnt <= 16'h0;
        end else if (tick) begin
          per_cnt <= fire[g] ? 16'h0 : per_cnt + 16'd1;
        end
      end
    end
  endgenerate

  // mask of lower messages sharing a pgn
  function [5:0] members_below;
    input integer n;
    input [17:0]  p;
    integer k;
    begin
      members_below = 6'h0;
      for (k = 0; k < 6; k = k + 1)
        if (k < n && pgn[k] == p)
          members_below[k] = 1'b1;
    end
  endfunction

  // bundle members and lowest pending leader
  always @* begin
    pick   = 6'h0;
    pick_n = 3'd0;
    for (i = 5; i >= 0; i = i - 1) begin
      members[i] = 6'h0;
      if (tx_pend[i]) begin
        pick   = 6'h1 << i;
        pick_n = i[2:0];
      end
    end
    for (i = 0; i < 6; i = i + 1) begin
      if (pgn[i] == pgn[0]) members[0][i] = 1'b1;
      if (pgn[i] == pgn[1] && i >= 1) members[1][i] = 1'b1;
      if (pgn[i] == pgn[2] && i >= 2) members[2][i] = 1'b1;
      if (pgn[i] == pgn[3] && i >= 3) members[3][i] = 1'b1;
      if (pgn[i] == pgn[4] && i >= 4) members[4][i] = 1'b1;
      if (pgn[i] == pgn[5] && i >= 5) members[5][i] = 1'b1;
    end
  end

  // apb slave: one wait state, registered answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready <= acc;
      if (acc) begin
        pslverr <= ~mapped;
        if (!pwrite && mapped)
          prdata <= (idx == `CLF_IDX_STATUS) ? status : cfg[idx];
        else
          prdata <= 32'h0;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // register file and variable block
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (rf_i = 0; rf_i < `CLF_NUM_CFG; rf_i = rf_i + 1)
        cfg[rf_i] <= 32'h0;
      for (rf_i = 0; rf_i < 6; rf_i = rf_i + 1) begin
        // proprietary b broadcast, priority 6, all signals used
        cfg[`CLF_IDX_TX_PGN0 + rf_i] <= {3'h0, `CLF_GLOBAL_ADDR, `CLF_PRIO_RESET,
                                         `CLF_PGN_PROPB_BASE + rf_i[17:0]};
        cfg[`CLF_IDX_TX_RATE0 + rf_i] <= {12'h0, `CLF_SIGEN_RESET, 16'h0};
      end
      save_armed <= 1'b1;
      gap_cnt    <= 14'd0;
      nv_save    <= 1'b0;
      nv_data    <= 32'h0;
    end else begin
      nv_save <= do_save;
      // software write; a save in the same cycle wins the variable
      if (wr_ok && idx != `CLF_IDX_STATUS)
        cfg[idx] <= pwdata;
      if (do_save) begin
        cfg[`CLF_IDX_VAR_VALUE] <= cfg[`CLF_IDX_VAR_DATA];
        nv_data    <= cfg[`CLF_IDX_VAR_DATA];
        save_armed <= 1'b0;
        gap_cnt    <= `CLF_SAVE_GAP_MS;
      end else begin
        if (!var_true)
          save_armed <= 1'b1;
        if (tick && gap_cnt != 14'd0)
          gap_cnt <= gap_cnt - 14'd1;
      end
    end
  end

  // millisecond tick and power-up hold-off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 18'h0;
      tick     <= 1'b0;
      hold_cnt <= `CLF_HOLDOFF_MS;
    end else begin
      // one pulse each time the prescaler wraps
      tick     <= (tick_cnt == TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 18'h0 : tick_cnt + 18'd1;
      if (tick && hold_cnt != 13'd0)
        hold_cnt <= hold_cnt - 13'd1;
    end
  end

  // conditional block and set/reset latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_out <= 1'b0;
      set_on   <= 1'b0;
      rst_on   <= 1'b0;
      sr_out   <= 1'b0;
    end else begin
      case (cfg[`CLF_IDX_COND_OPS][`CLF_OP3_LSB +: 2])
        2'd1: cond_out <= op1_res | op2_res;
        2'd2: cond_out <= op1_res & op2_res;
        2'd3: cond_out <= op1_res ^ op2_res;
        default: cond_out <= 1'b0;
      endcase
      // thresholded inputs add a cycle before the latch sees them
      set_on <= thr_state(cfg[`CLF_IDX_SR_SET], cfg[`CLF_IDX_SR_THR][`CLF_SET_MIN_LSB +: 8],
                          cfg[`CLF_IDX_SR_THR][`CLF_SET_MAX_LSB +: 8], set_on);
      rst_on <= thr_state(cfg[`CLF_IDX_SR_RST], cfg[`CLF_IDX_SR_THR][`CLF_RST_MIN_LSB +: 8],
                          cfg[`CLF_IDX_SR_THR][`CLF_RST_MAX_LSB +: 8], rst_on);
      if (rst_on)
        sr_out <= 1'b0;
      else if (set_on)
        sr_out <= 1'b1;
    end
  end

  // dtc react: five pairs, each with its own silence timer
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_dtc
      reg  [11:0] age;   // ms since last match
      wire [31:0] c = cfg[`CLF_IDX_DTC_CFG0 + g];   // spn and fmi of this pair
      // a zero spn marks the pair unused, so it never matches
      assign dtc_hit[g] = dm1_valid && (c[18:0] != 19'h0) && (dm1_spn == c[18:0]) &&
                          (dm1_fmi == c[`CLF_DTC_FMI_LSB +: 5]);
      // last tick of the hold time with no fresh match
      assign dtc_expire[g] = tick && dtc_state[g] &&
                             (age == `CLF_DTC_HOLD_MS - 12'd1);
      // silence timer, restarted by every match
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          age <= 12'h0;
        end else if (dtc_hit[g]) begin
          age <= 12'h0;
        end else if (tick && dtc_state[g]) begin
          age <= age + 12'd1;
        end
      end
    end
  endgenerate

  // all states in one register; a match beats a timeout in one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtc_state <= 5'h0;
    end else begin
      dtc_state <= dtc_hit | (dtc_state & ~dtc_expire);
    end
  end

  // transmit: queue expired leaders, send lowest pending one per cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pend   <= 6'h0;
      tx_req    <= 1'b0;
      tx_bundle <= 6'h0;
      tx_pgn    <= 18'h0;
      tx_prio   <= 3'd0;
      tx_da     <= 8'h0;
      tx_sig_en <= 24'h0;
    end else begin
      // a leader expiring while still pending is merged, not queued twice
      tx_pend <= (tx_pend & ~pick) | fire;
      tx_req  <= |pick;
      if (|pick) begin
        tx_bundle <= members[pick_n];
        tx_pgn    <= pgn[pick_n];
        tx_prio   <= cfg[`CLF_IDX_TX_PGN0 + pick_n][`CLF_TX_PRIO_LSB +: 3];
        // pdu1 uses the configured address, pdu2 is always broadcast
        tx_da <= (pgn[pick_n][15:8] < `CLF_PF_PDU2_MIN) ?
                 cfg[`CLF_IDX_TX_PGN0 + pick_n][`CLF_TX_DA_LSB +: 8] :
                 `CLF_GLOBAL_ADDR;
        for (tx_i = 0; tx_i < 6; tx_i = tx_i + 1)
          tx_sig_en[tx_i*4 +: 4] <= members[pick_n][tx_i] ?
                                 cfg[`CLF_IDX_TX_RATE0 + tx_i][`CLF_TX_SIGEN_LSB +: 4] :
                                 4'h0;
      end
    end
  end

endmodule

// ===== dv/clf_properties.sv
// assertion checker for the logic block top
`timescale 1ns/1ps
module clf_properties #(
  parameter TICK_CYCLES = 200000
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire        dm1_valid,
  input wire        nv_save,
  input wire [4:0]  dtc_state,
  input wire        tx_req,
  input wire [5:0]  tx_bundle,
  input wire [17:0] tx_pgn,
  input wire [7:0]  tx_da,
  input wire [23:0] tx_sig_en
);
  localparam int GAP = 10000 * TICK_CYCLES; // save spacing
  localparam int HOLD = 5000 * TICK_CYCLES; // transmit hold-off
  localparam int DTC = 3000 * TICK_CYCLES;  // fault hold time
  int          up_cnt;   // cycles since reset release
  int          gap_cnt;  // cycles since last save
  int          idle_cnt; // cycles since last fault report
  logic        saved;    // a save has happened
  logic [23:0] member;   // enables allowed by the bundle
  int          on_cnt [5]; // cycles each fault state has been on
  logic [4:0]  young;    // fault state on for less than the hold time minus two ticks
  // four enable bits per bundle member
  always_comb for (int i = 0; i < 24; i++) member[i] = tx_bundle[i / 4];
  always_comb for (int j = 0; j < 5; j++) young[j] = on_cnt[j] < DTC - 2 * TICK_CYCLES;
  // elapsed-time counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 0;
      gap_cnt <= 0;
      idle_cnt <= 0;
      saved <= 1'b0;
      for (int j = 0; j < 5; j++) on_cnt[j] <= 0;
    end else begin
      up_cnt <= up_cnt + 1;
      gap_cnt <= nv_save ? 1 : gap_cnt + 1;
      idle_cnt <= dm1_valid ? 0 : idle_cnt + 1;
      saved <= saved | nv_save;
      for (int j = 0; j < 5; j++) on_cnt[j] <= dtc_state[j] ? on_cnt[j] + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_SAVE_ONCE: assert property (nv_save |=> !nv_save)
    else $error("save pulse repeated");
  AST_SAVE_GAP: assert property (nv_save && saved |-> gap_cnt >= GAP - TICK_CYCLES)
    else $error("saves too close");
  AST_HOLDOFF: assert property (tx_req |-> up_cnt >= HOLD - TICK_CYCLES)
    else $error("transmit during hold-off");
  AST_DTC_SET: assert property ((dtc_state & ~$past(dtc_state)) != 0 |-> $past(dm1_valid))
    else $error("fault state set without report");
  AST_DTC_KEEP: assert property (|($past(dtc_state) & ~dtc_state) |->
    ($past(young) & $past(dtc_state) & ~dtc_state) == 0)
    else $error("fault state cleared early");
  AST_DTC_CLEAR: assert property (idle_cnt > DTC + 2 * TICK_CYCLES + 4 |-> dtc_state == 0)
    else $error("fault state not cleared");
  AST_TX_BUNDLE: assert property (tx_req |-> tx_bundle != 0 && (tx_sig_en & ~member) == 0)
    else $error("bad bundle or signal enables");
  AST_TX_DA: assert property (tx_req && tx_pgn[15:8] >= 8'hf0 |-> tx_da == 8'hff)
    else $error("destination used on broadcast pgn");
endmodule

bind clf_top clf_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .dm1_valid(dm1_valid), .nv_save(nv_save),
  .dtc_state(dtc_state), .tx_req(tx_req), .tx_bundle(tx_bundle), .tx_pgn(tx_pgn),
  .tx_da(tx_da), .tx_sig_en(tx_sig_en)
);

// ===== dv/clf_ecu_model.sv
// far-side node model: sends fault reports, logs transmitted bundles
`timescale 1ns/1ps
module clf_ecu_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        tx_req,
  input  wire [5:0]  tx_bundle,
  input  wire [17:0] tx_pgn,
  input  wire [2:0]  tx_prio,
  input  wire [7:0]  tx_da,
  input  wire [23:0] tx_sig_en,
  output reg         dm1_valid,
  output reg  [18:0] dm1_spn,
  output reg  [4:0]  dm1_fmi
);
  integer    cyc = 0;  // cycle count
  integer    ld;       // leader of a bundle
  integer    j;        // loop index
  integer    cnt[0:5]; // bundles per leader
  integer    gap[0:5]; // last spacing per leader
  integer    lst[0:5]; // cycle of last bundle per leader
  reg [58:0] rec[0:5]; // last fields per leader
  initial begin
    {dm1_valid, dm1_spn, dm1_fmi} = 0;
    for (j = 0; j < 6; j++) begin
      cnt[j] = 0;
      gap[j] = 0;
      lst[j] = 0;
    end
  end
  // one report, then the lines show the inverse of the last pair
  task send_dm1(input [18:0] spn, input [4:0] fmi);
    begin
      @(posedge pclk);
      dm1_valid <= 1'b1;
      dm1_spn <= spn;
      dm1_fmi <= fmi;
      @(posedge pclk);
      dm1_valid <= 1'b0;
      dm1_spn <= ~spn;
      dm1_fmi <= ~fmi;
    end
  endtask
  // log each bundle under its lowest member
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ld = 6;
    for (j = 5; j >= 0; j--) if (tx_bundle[j]) ld = j;
    if (presetn && tx_req === 1'b1 && ld < 6) begin
      rec[ld] <= {tx_bundle, tx_pgn, tx_prio, tx_da, tx_sig_en};
      cnt[ld] <= cnt[ld] + 1;
      gap[ld] <= cyc - lst[ld];
      lst[ld] <= cyc;
    end
  end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the logic blocks
`timescale 1ns/1ps
`include "clf_defines.vh"
module testbench;
  localparam T = 2;             // shortened tick in cycles
  reg         pclk = 0;         // bus clock
  reg         presetn = 0;      // reset, active low
  reg         psel = 0;         // apb select
  reg         penable = 0;      // apb access phase
  reg         pwrite = 0;       // apb direction
  reg  [31:0] paddr = 0;        // apb address
  reg  [31:0] pwdata = 0;       // apb write data
  wire [31:0] prdata, nv_data;  // read data, saved value
  wire        pready, pslverr, dm1_valid, nv_save, cond_out, sr_out, tx_req;
  wire [18:0] dm1_spn;          // reported spn
  wire [4:0]  dm1_fmi, dtc_state;
  wire [5:0]  tx_bundle;        // bundle mask
  wire [17:0] tx_pgn;           // leader pgn
  wire [2:0]  tx_prio;          // leader priority
  wire [7:0]  tx_da;            // leader destination
  wire [23:0] tx_sig_en;        // signal enables
  integer     fail_count = 0;   // mismatches
  integer     n_tests = 0;      // comparisons
  integer     seed = 54149;     // random seed
  integer     cyc = 0;          // cycle count
  integer     n_save = 0;       // saves seen
  integer     save_cyc = 0;     // cycle of last save
  integer     i, k, e, r, o1, o2, o3, ss, rs, st, x[0:3];
  reg  [31:0] rd, d;            // read data, random data
  reg         err;              // read error flag
  reg  [55:0] sv = {8'd70, 8'd70, 8'd70, 8'd10, 8'd10, 8'd40, 8'd70}; // set steps
  reg  [55:0] rv = {8'd10, 8'd40, 8'd70, 8'd40, 8'd0, 8'd0, 8'd0};    // reset steps
  clf_top #(.TICK_CYCLES(T)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dm1_valid(dm1_valid), .dm1_spn(dm1_spn), .dm1_fmi(dm1_fmi), .nv_save(nv_save),
    .nv_data(nv_data), .cond_out(cond_out), .sr_out(sr_out), .dtc_state(dtc_state),
    .tx_req(tx_req), .tx_bundle(tx_bundle), .tx_pgn(tx_pgn), .tx_prio(tx_prio),
    .tx_da(tx_da), .tx_sig_en(tx_sig_en));
  clf_ecu_model u_ecu (
    .pclk(pclk), .presetn(presetn), .tx_req(tx_req), .tx_bundle(tx_bundle),
    .tx_pgn(tx_pgn), .tx_prio(tx_prio), .tx_da(tx_da), .tx_sig_en(tx_sig_en),
    .dm1_valid(dm1_valid), .dm1_spn(dm1_spn), .dm1_fmi(dm1_fmi));
  always #2.5 pclk = ~pclk;
  // count saves as the far side would see them
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (nv_save === 1'b1) begin
      n_save <= n_save + 1;
      save_cyc <= cyc;
    end
  end
  task finish_test;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [8*4-1:0] nm, input [31:0] ex, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== ex) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task apb(input w, input [4:0] ix, input [31:0] wd);
    integer n;
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 25'd0, ix, 2'b00, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // look between edges, where ready, data and error have settled
      @(negedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(negedge pclk);
      end
      if (n == 20) begin
        fail_count = fail_count + 1;
        finish_test;
      end
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      {psel, penable} <= 2'b00;
    end
  endtask
  // comparator and gate model, truth is nonzero
  function integer cmpf(input integer op, input integer a, input integer b);
    case (op)
      1: cmpf = a == b;
      2: cmpf = a != b;
      3: cmpf = a > b;
      4: cmpf = a >= b;
      5: cmpf = a < b;
      6: cmpf = a <= b;
      7: cmpf = a != 0 || b != 0;
      8: cmpf = a != 0 && b != 0;
      9: cmpf = (a != 0) ^ (b != 0);
      default: cmpf = 0;
    endcase
  endfunction
  task txchk(input integer l, input [5:0] b, input [17:0] p, input [10:0] pd, input [23:0] s);
    begin
      chk("bndl", b, u_ecu.rec[l][58:53]);
      chk("pgn", p, u_ecu.rec[l][52:35]);
      chk("prda", pd, u_ecu.rec[l][34:24]);
      chk("sig", s, u_ecu.rec[l][23:0]);
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk("sr", 0, sr_out);
    for (i = 0; i < 6; i++) begin
      apb(0, `CLF_IDX_TX_PGN0 + i[4:0], 0);
      chk("pgnr", (32'hff << 21) | (6 << 18) | (32'h0ff00 + i), rd);
      apb(0, `CLF_IDX_TX_RATE0 + i[4:0], 0);
      chk("rate", 32'h000f0000, rd);
    end
    apb(0, 5'd31, 0);
    chk("err", 1, err);
    chk("rd", 0, rd);
    apb(1, `CLF_IDX_TX_PGN0, (3 << 18) | (32'h22 << 21) | 32'h0ef00);
    apb(1, `CLF_IDX_TX_PGN0 + 5'd1, (5 << 18) | 32'h0ef00);
    apb(1, `CLF_IDX_TX_RATE0, 32'h000a0003);
    apb(1, `CLF_IDX_TX_RATE0 + 5'd1, 32'h00050000);
    apb(1, `CLF_IDX_TX_RATE0 + 5'd3, 32'h000f0004);
    for (k = 0; k < 30; k++) begin
      for (i = 0; i < 4; i++) begin
        x[i] = $random(seed) & 3;
        apb(1, `CLF_IDX_COND_IN1 + i[4:0], x[i]);
      end
      o1 = k < 10 ? k : {$random(seed)} % 10;
      o2 = k < 10 ? 0 : k < 20 ? k - 10 : {$random(seed)} % 10;
      o3 = k < 20 ? 1 : k % 4;
      apb(1, `CLF_IDX_COND_OPS, o1 | (o2 << 4) | (o3 << 8));
      repeat (3) @(posedge pclk);
      e = cmpf(o1, x[0], x[1]);
      r = cmpf(o2, x[2], x[3]);
      chk("cond", o3 ? cmpf(o3 + 6, e, r) : 0, cond_out);
    end
    chk("hold", 0, u_ecu.cnt[0]);
    apb(1, `CLF_IDX_SR_THR, 32'h3c143c14);
    {ss, rs, st} = 0;
    for (k = 0; k < 7; k++) begin
      apb(1, `CLF_IDX_SR_SET, sv[8*k+:8]);
      apb(1, `CLF_IDX_SR_RST, rv[8*k+:8]);
      ss = sv[8*k+:8] >= 60 ? 1 : sv[8*k+:8] <= 20 ? 0 : ss;
      rs = rv[8*k+:8] >= 60 ? 1 : rv[8*k+:8] <= 20 ? 0 : rs;
      st = rs ? 0 : ss ? 1 : st;
      repeat (4) @(posedge pclk);
      chk("sr", st, sr_out);
    end
    apb(1, `CLF_IDX_VAR_VALUE, 32'h1234);
    apb(0, `CLF_IDX_VAR_VALUE, 0);
    chk("var", 32'h1234, rd);
    d = $random(seed);
    apb(1, `CLF_IDX_VAR_DATA, d);
    apb(1, `CLF_IDX_VAR_THR, 5);
    apb(1, `CLF_IDX_VAR_FUNC, 1);
    apb(1, `CLF_IDX_VAR_TRIG, 5);
    repeat (4) @(posedge pclk);
    chk("save", 1, n_save);
    chk("nvd", d, nv_data);
    apb(0, `CLF_IDX_VAR_VALUE, 0);
    chk("var", d, rd);
    apb(1, `CLF_IDX_VAR_DATA, ~d);
    apb(1, `CLF_IDX_VAR_FUNC, 10);
    apb(1, `CLF_IDX_VAR_TRIG, 6);
    while (cyc < save_cyc + 10000 * T - 10) @(posedge pclk);
    chk("save", 1, n_save);
    repeat (40) @(posedge pclk);
    chk("save", 2, n_save);
    chk("nvd", ~d, nv_data);
    apb(1, `CLF_IDX_DTC_CFG0, (4 << 19) | 123);
    apb(1, `CLF_IDX_DTC_CFG0 + 5'd1, (2 << 19) | 77);
    u_ecu.send_dm1(123, 4);
    u_ecu.send_dm1(77, 4);
    repeat (3) @(posedge pclk);
    chk("dtc", 1, dtc_state);
    repeat (1000 * T) @(posedge pclk);
    u_ecu.send_dm1(123, 4);
    repeat (2900 * T) @(posedge pclk);
    chk("dtc", 1, dtc_state);
    repeat (200 * T) @(posedge pclk);
    chk("dtc", 0, dtc_state);
    txchk(0, 6'h03, 18'h0ef00, {3'd3, 8'h22}, 24'h00005a);
    txchk(3, 6'h08, 18'h0ff03, {3'd6, 8'hff}, 24'h00f000);
    chk("gap", 3 * T, u_ecu.gap[0]);
    chk("cnt1", 0, u_ecu.cnt[1]);
    chk("cnt2", 0, u_ecu.cnt[2]);
    finish_test;
  end
endmodule
